// ===== hdl/dph_consts.vh
/*
 * Constants of the four-stage pipeline control block: indices of the
 * memory-mapped register file, field positions, reset values and the
 * byte addresses of the software port.
 * Assumes inclusion by bare name from the design file only.
 */
`ifndef DPH_CONSTS_VH
`define DPH_CONSTS_VH

// Memory-mapped register indices (software byte address is four times these)
`define DPH_IDX_AR0      5'h00
`define DPH_IDX_AR7      5'h07
`define DPH_IDX_INDEX    5'h08
`define DPH_IDX_AUX_COMPARE_REG     5'h09
`define DPH_IDX_GLOBAL_ALLOC_REG     5'h0a
`define DPH_IDX_PROCESSOR_MODE_REG     5'h0b
`define DPH_IDX_SHIFT    5'h0c
`define DPH_IDX_BITADR   5'h0d
`define DPH_IDX_CBSR1    5'h0e
`define DPH_IDX_CBSR2    5'h0f
`define DPH_IDX_CBER1    5'h10
`define DPH_IDX_CBER2    5'h11
`define DPH_IDX_CIRC_CONTROL_REG     5'h12
`define DPH_IDX_BLOCK_MOVE_ADDR_REG     5'h13
`define DPH_IDX_PROGDATA_WAIT_REG    5'h14
`define DPH_IDX_IO_WAIT_REG    5'h15
`define DPH_IDX_WAIT_CONTROL_REG     5'h16
`define DPH_IDX_LAST     5'h16

// Circular buffer control fields
`define DPH_CIRC_CONTROL_REG_CAR1_LO 0
`define DPH_CIRC_CONTROL_REG_CAR1_HI 2
`define DPH_CIRC_CONTROL_REG_CENB1   3
`define DPH_CIRC_CONTROL_REG_CAR2_LO 4
`define DPH_CIRC_CONTROL_REG_CAR2_HI 6
`define DPH_CIRC_CONTROL_REG_CENB2   7

// Reset values
`define DPH_RST_REG      16'h0000
`define DPH_RST_CNF      1'b0
`define DPH_RST_CTRL     1'b0

// Software port byte addresses and position of the hold bit in the control word
`define DPH_SW_CTRL      8'h60
`define DPH_SW_STAT      8'h64
`define DPH_SW_DROPS     8'h68
`define DPH_CTRL_HOLD    0

`endif

// ===== hdl/dph_pipe_ctrl.v
/*
 * Pipeline control of a four-stage fixed-point signal processor core:
 * fetch, decode, operand fetch and execute, with the memory-mapped
 * register file and the timing of address-unit updates, mapped writes,
 * normalize effects and memory remapping.
 * Assumes instruction words arrive already decoded from logic on the
 * same clock, one word per cycle, and a software port with one-cycle reads.
 */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "dph_consts.vh"
// Notes on behaviour
// RULE_01 - four overlapping stages, one word each
// RULE_02 - address unit updates registers in decode
// RULE_03 - mapped aux register writes land in execute
// RULE_04 - index and compare writes land in execute
// RULE_05 - same-cycle collision: decode update wins
// RULE_06 - next word old value, second overwrites
// RULE_07 - global allocation: next word keeps old map
// RULE_08 - processor mode: next two words old map
// RULE_09 - shift count, bit address: one-word latency
// RULE_10 - circular start: next two words old value
// RULE_11 - circular end/control: two-word latency
// RULE_12 - block move address: one-word latency
// RULE_13 - wait-state registers: one-word latency
// RULE_14 - ram map bit: next two words old map
// RULE_15 - direct register loads are interlocked
// RULE_16 - later reads see writes after latency
// RULE_17 - normalize modifies selected register in execute
// RULE_18 - remapping lands in execute, two words later
// RULE_19 - two single or one double word
// RULE_20 - interrupt return restore also two words late
// RULE_21 - one stage per cycle, never stalls

module dph_pipe_ctrl (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst,
	// Fetched instruction word
	input  wire        in_valid,
	input  wire        in_ar_upd,
	input  wire        in_ar_use_idx,
	input  wire        in_ar_cmp,
	input  wire        in_ar_load,
	input  wire [2:0]  in_aux_pointer,
	input  wire [15:0] in_ar_delta,
	input  wire [15:0] in_ar_load_val,
	input  wire        in_mmr_wr,
	input  wire [4:0]  in_mmr_sel,
	input  wire [15:0] in_mmr_data,
	input  wire        in_normalize_op,
	input  wire        in_cnf_wr,
	input  wire        in_cnf_val,
	// Operand fetch stage view
	output reg         op_valid,
	output reg  [15:0] op_addr,
	output reg  [15:0] op_processor_mode_reg,
	output reg         op_ram_map_select_bit,
	output reg         aux_cmp_tc,
	// Execute stage view
	output reg         ex_valid,
	output reg  [15:0] ex_global_alloc_reg,
	output reg  [15:0] ex_dyn_shift_count,
	output reg  [15:0] ex_dyn_bit_address,
	output reg  [15:0] ex_block_move_addr_reg,
	output reg  [15:0] ex_progdata_wait_reg,
	output reg  [15:0] ex_io_wait_reg,
	output reg  [15:0] ex_wait_control_reg,
	output reg         mmr_drop,
	// Software port
	input  wire [7:0]  sw_addr,
	input  wire [31:0] sw_wdata,
	input  wire        sw_wr,
	input  wire        sw_rd,
	output reg  [31:0] sw_rdata
);

	// Memory-mapped register file and ram map bit
	reg [15:0] mreg [0:22];
	reg        cnf_r;
	reg        hold_r;
	reg [15:0] drops_r;

	// Fetch stage word
	reg        f_valid_r;
	reg        f_upd_r;
	reg        f_idx_r;
	reg        f_cmp_r;
	reg        f_load_r;
	reg [2:0]  f_sel_r;
	reg [15:0] f_delta_r;
	reg [15:0] f_ldv_r;
	reg        f_mwr_r;
	reg [4:0]  f_msel_r;
	reg [15:0] f_mdat_r;
	reg        f_normalize_op_r;
	reg        f_cwr_r;
	reg        f_cval_r;

	// Decode stage word
	reg        d_valid_r;
	reg        d_upd_r;
	reg        d_idx_r;
	reg        d_cmp_r;
	reg        d_load_r;
	reg [2:0]  d_sel_r;
	reg [15:0] d_delta_r;
	reg [15:0] d_ldv_r;
	reg        d_mwr_r;
	reg [4:0]  d_msel_r;
	reg [15:0] d_mdat_r;
	reg        d_normalize_op_r;
	reg        d_cwr_r;
	reg        d_cval_r;

	// Operand fetch stage word
	reg        o_mwr_r;
	reg [4:0]  o_msel_r;
	reg [15:0] o_mdat_r;
	reg        o_normalize_op_r;
	reg [2:0]  o_sel_r;
	reg [15:0] o_delta_r;
	reg        o_cwr_r;
	reg        o_cval_r;

	// Execute stage word
	reg        e_mwr_r;
	reg [4:0]  e_msel_r;
	reg [15:0] e_mdat_r;
	reg        e_normalize_op_r;
	reg [2:0]  e_sel_r;
	reg [15:0] e_delta_r;
	reg        e_cwr_r;
	reg        e_cval_r;

	// Decode-stage address arithmetic
	wire [15:0] ar_cur;
	wire [15:0] d_step;
	wire [16:0] d_sum;
	wire [15:0] circ_control_reg;
	wire        circ1_hit;
	wire        circ2_hit;
	reg  [15:0] ar_nxt;
	wire        d_ar_wr;

	assign ar_cur = mreg[{2'b00, d_sel_r}];
	assign d_step = d_idx_r ? mreg[`DPH_IDX_INDEX] : d_delta_r; // [RULE_04]
	assign d_sum = {1'b0, ar_cur} + {1'b0, d_step};
	assign circ_control_reg = mreg[`DPH_IDX_CIRC_CONTROL_REG];
	// End-of-buffer tests read the live circular registers in decode
	assign circ1_hit = circ_control_reg[`DPH_CIRC_CONTROL_REG_CENB1]
		&& (circ_control_reg[`DPH_CIRC_CONTROL_REG_CAR1_HI:`DPH_CIRC_CONTROL_REG_CAR1_LO] == d_sel_r)
		&& (ar_cur == mreg[`DPH_IDX_CBER1]); // [RULE_11]
	assign circ2_hit = circ_control_reg[`DPH_CIRC_CONTROL_REG_CENB2]
		&& (circ_control_reg[`DPH_CIRC_CONTROL_REG_CAR2_HI:`DPH_CIRC_CONTROL_REG_CAR2_LO] == d_sel_r)
		&& (ar_cur == mreg[`DPH_IDX_CBER2]); // [RULE_11]
	assign d_ar_wr = d_valid_r && (d_upd_r || d_load_r); // [RULE_02] [RULE_15]

	// Next value of the decode-selected aux register
	always @* begin
		if (d_load_r) begin
			ar_nxt = d_ldv_r; // [RULE_15]
		end else if (circ1_hit) begin
			ar_nxt = mreg[`DPH_IDX_CBSR1]; // [RULE_10]
		end else if (circ2_hit) begin
			ar_nxt = mreg[`DPH_IDX_CBSR2]; // [RULE_10]
		end else begin
			ar_nxt = d_sum[15:0]; // [RULE_02]
		end
	end

	// Execute-stage writes and their collision with decode
	wire       e_mmr_ok;
	wire       e_mmr_ar;
	wire       e_mmr_kill;
	wire       e_normalize_op_kill;
	wire [16:0] e_normalize_op_sum;
	wire [15:0] e_normalize_op_cur;
	wire [16:0] drops_inc;

	assign e_mmr_ok = e_mwr_r && (e_msel_r <= `DPH_IDX_LAST);
	assign e_mmr_ar = (e_msel_r <= `DPH_IDX_AR7);
	assign e_mmr_kill = e_mmr_ok && e_mmr_ar && d_ar_wr
		&& (e_msel_r == {2'b00, d_sel_r}); // [RULE_05] [RULE_06]
	assign e_normalize_op_kill = e_normalize_op_r && d_ar_wr && (e_sel_r == d_sel_r); // [RULE_17]
	assign e_normalize_op_cur = mreg[{2'b00, e_sel_r}];
	assign e_normalize_op_sum = {1'b0, e_normalize_op_cur} + {1'b0, e_delta_r};
	assign drops_inc = {1'b0, drops_r} + 17'h00001;

	// Register file: execute writes first, decode updates override
	integer i;
	always @(posedge ref_clk) begin
		if (rst) begin
			for (i = 0; i <= 22; i = i + 1) begin
				mreg[i] <= `DPH_RST_REG;
			end
			cnf_r <= `DPH_RST_CNF;
		end else begin
			if (e_mmr_ok && !e_mmr_kill) begin
				mreg[e_msel_r] <= e_mdat_r; // [RULE_03] [RULE_04] [RULE_16]
			end
			if (e_normalize_op_r && !e_normalize_op_kill) begin
				mreg[{2'b00, e_sel_r}] <= e_normalize_op_sum[15:0]; // [RULE_17]
			end
			if (d_ar_wr) begin
				mreg[{2'b00, d_sel_r}] <= ar_nxt; // [RULE_02] [RULE_05]
			end
			if (e_cwr_r) begin
				cnf_r <= e_cval_r; // [RULE_14] [RULE_18] [RULE_20]
			end
		end
	end

	// Stage advance: every word moves one stage per cycle
	always @(posedge ref_clk) begin
		if (rst) begin
			f_valid_r <= 1'b0;
			d_valid_r <= 1'b0;
			op_valid  <= 1'b0;
			ex_valid  <= 1'b0;
		end else begin
			f_valid_r <= in_valid && !hold_r; // [RULE_01] [RULE_21]
			d_valid_r <= f_valid_r; // [RULE_21]
			op_valid  <= d_valid_r; // [RULE_21]
			ex_valid  <= op_valid; // [RULE_21]
		end
	end

	// Word fields: bubbles carry no effects
	always @(posedge ref_clk) begin
		if (rst) begin
			f_upd_r <= 1'b0;
			f_load_r <= 1'b0;
			f_mwr_r <= 1'b0;
			f_normalize_op_r <= 1'b0;
			f_cwr_r <= 1'b0;
			f_cmp_r <= 1'b0;
			d_upd_r <= 1'b0;
			d_load_r <= 1'b0;
			d_mwr_r <= 1'b0;
			d_normalize_op_r <= 1'b0;
			d_cwr_r <= 1'b0;
			d_cmp_r <= 1'b0;
			o_mwr_r <= 1'b0;
			o_normalize_op_r <= 1'b0;
			o_cwr_r <= 1'b0;
			e_mwr_r <= 1'b0;
			e_normalize_op_r <= 1'b0;
			e_cwr_r <= 1'b0;
		end else begin
			f_upd_r  <= in_valid && !hold_r && in_ar_upd;
			f_load_r <= in_valid && !hold_r && in_ar_load;
			f_mwr_r  <= in_valid && !hold_r && in_mmr_wr;
			f_normalize_op_r <= in_valid && !hold_r && in_normalize_op;
			f_cwr_r  <= in_valid && !hold_r && in_cnf_wr;
			f_cmp_r  <= in_valid && !hold_r && in_ar_cmp;
			d_upd_r  <= f_upd_r;
			d_load_r <= f_load_r;
			d_mwr_r  <= f_mwr_r;
			d_normalize_op_r <= f_normalize_op_r;
			d_cwr_r  <= f_cwr_r;
			d_cmp_r  <= f_cmp_r;
			o_mwr_r  <= d_mwr_r;
			o_normalize_op_r <= d_normalize_op_r;
			o_cwr_r  <= d_cwr_r;
			e_mwr_r  <= o_mwr_r;
			e_normalize_op_r <= o_normalize_op_r;
			e_cwr_r  <= o_cwr_r;
		end
	end

	// Word data fields, no reset needed beyond the enables above
	always @(posedge ref_clk) begin
		f_idx_r   <= in_ar_use_idx;
		f_sel_r   <= in_aux_pointer;
		f_delta_r <= in_ar_delta;
		f_ldv_r   <= in_ar_load_val;
		f_msel_r  <= in_mmr_sel;
		f_mdat_r  <= in_mmr_data;
		f_cval_r  <= in_cnf_val;
		d_idx_r   <= f_idx_r;
		d_sel_r   <= f_sel_r;
		d_delta_r <= f_delta_r;
		d_ldv_r   <= f_ldv_r;
		d_msel_r  <= f_msel_r;
		d_mdat_r  <= f_mdat_r;
		d_cval_r  <= f_cval_r;
		o_msel_r  <= d_msel_r;
		o_mdat_r  <= d_mdat_r;
		o_sel_r   <= d_sel_r;
		o_delta_r <= d_delta_r;
		o_cval_r  <= d_cval_r;
		e_msel_r  <= o_msel_r;
		e_mdat_r  <= o_mdat_r;
		e_sel_r   <= o_sel_r;
		e_delta_r <= o_delta_r;
		e_cval_r  <= o_cval_r;
	end

	// Decode-read values handed to operand fetch
	always @(posedge ref_clk) begin
		if (rst) begin
			op_addr <= 16'h0000;
			op_processor_mode_reg <= `DPH_RST_REG;
			op_ram_map_select_bit <= `DPH_RST_CNF;
			aux_cmp_tc <= 1'b0;
		end else begin
			op_addr <= ar_cur; // [RULE_02] [RULE_06]
			op_processor_mode_reg <= mreg[`DPH_IDX_PROCESSOR_MODE_REG]; // [RULE_08] [RULE_18]
			op_ram_map_select_bit <= cnf_r; // [RULE_14] [RULE_19] [RULE_20]
			if (d_valid_r && d_cmp_r) begin
				aux_cmp_tc <= (ar_cur == mreg[`DPH_IDX_AUX_COMPARE_REG]); // [RULE_04]
			end
		end
	end

	// Operand-fetch-read values handed to execute
	always @(posedge ref_clk) begin
		if (rst) begin
			ex_global_alloc_reg <= `DPH_RST_REG;
			ex_dyn_shift_count <= `DPH_RST_REG;
			ex_dyn_bit_address <= `DPH_RST_REG;
			ex_block_move_addr_reg <= `DPH_RST_REG;
			ex_progdata_wait_reg <= `DPH_RST_REG;
			ex_io_wait_reg <= `DPH_RST_REG;
			ex_wait_control_reg <= `DPH_RST_REG;
		end else begin
			ex_global_alloc_reg <= mreg[`DPH_IDX_GLOBAL_ALLOC_REG]; // [RULE_07] [RULE_16]
			ex_dyn_shift_count <= mreg[`DPH_IDX_SHIFT]; // [RULE_09]
			ex_dyn_bit_address <= mreg[`DPH_IDX_BITADR]; // [RULE_09]
			ex_block_move_addr_reg <= mreg[`DPH_IDX_BLOCK_MOVE_ADDR_REG]; // [RULE_12]
			ex_progdata_wait_reg <= mreg[`DPH_IDX_PROGDATA_WAIT_REG]; // [RULE_13]
			ex_io_wait_reg <= mreg[`DPH_IDX_IO_WAIT_REG]; // [RULE_13]
			ex_wait_control_reg <= mreg[`DPH_IDX_WAIT_CONTROL_REG]; // [RULE_13]
		end
	end

	// Voided mapped and normalize writes: pulse and running count
	always @(posedge ref_clk) begin
		if (rst) begin
			mmr_drop <= 1'b0;
			drops_r <= 16'h0000;
		end else begin
			mmr_drop <= e_mmr_kill || e_normalize_op_kill; // [RULE_05] [RULE_17]
			if (e_mmr_kill || e_normalize_op_kill) begin
				drops_r <= drops_inc[15:0];
			end
		end
	end

	// Software control: hold turns fetched words into bubbles
	always @(posedge ref_clk) begin
		if (rst) begin
			hold_r <= `DPH_RST_CTRL;
		end else if (sw_wr && (sw_addr == `DPH_SW_CTRL)) begin
			hold_r <= sw_wdata[`DPH_CTRL_HOLD];
		end
	end

	// Software read, data in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rst) begin
			sw_rdata <= 32'h00000000;
		end else if (sw_rd) begin
			if ((sw_addr[1:0] == 2'b00) && (sw_addr[7:2] <= {1'b0, `DPH_IDX_LAST})) begin
				sw_rdata <= {16'h0000, mreg[sw_addr[6:2]]};
			end else if (sw_addr == `DPH_SW_CTRL) begin
				sw_rdata <= {31'h00000000, hold_r};
			end else if (sw_addr == `DPH_SW_STAT) begin
				sw_rdata <= {27'h0000000, cnf_r, ex_valid, op_valid, d_valid_r, f_valid_r};
			end else if (sw_addr == `DPH_SW_DROPS) begin
				sw_rdata <= {16'h0000, drops_r};
			end else begin
				sw_rdata <= 32'h00000000;
			end
		end else begin
			sw_rdata <= 32'h00000000;
		end
	end

endmodule // dph_pipe_ctrl
`default_nettype wire

// ===== bench/dph_pipe_ctrl_props.sv
/* Port timing checks of the pipeline control block.
   Assumes a bind from the testbench top, one clock, synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module dph_pipe_ctrl_props (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// Stage flags
	input wire logic        in_valid,
	input wire logic        op_valid,
	input wire logic        ex_valid,
	input wire logic        mmr_drop,
	// Software port
	input wire logic [7:0]  sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic        sw_wr,
	input wire logic        sw_rd,
	input wire logic [31:0] sw_rdata
);
	logic hold_r;
	// Shadow of the hold bit, needed to tell bubbles from words
	always_ff @(posedge ref_clk)
		if (rst)
			hold_r <= 1'b0;
		else if (sw_wr && sw_addr == 8'h60)
			hold_r <= sw_wdata[0];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_OP_TAKE: assert property (in_valid && !hold_r |-> ##3 op_valid)
		else $error("word missing in operand fetch");
	AST_OP_IDLE: assert property (!in_valid || hold_r |-> ##3 !op_valid)
		else $error("operand fetch without word");
	AST_EX_TAKE: assert property (op_valid |=> ex_valid)
		else $error("word missing in execute");
	AST_EX_IDLE: assert property (!op_valid |=> !ex_valid)
		else $error("execute without word");
	AST_RD_IDLE: assert property (!sw_rd |=> sw_rdata == 32'h0)
		else $error("read data outside read slot");
	AST_RD_HOLD: assert property (sw_rd && sw_addr == 8'h60 |=> sw_rdata == {31'h0, $past(hold_r)})
		else $error("hold bit read back wrong");
	AST_RD_STAT: assert property (sw_rd && sw_addr == 8'h64 |=> sw_rdata[3:2] == {$past(ex_valid), $past(op_valid)})
		else $error("stage flags read back wrong");
	AST_RD_GAP: assert property (sw_rd && sw_addr > 8'h68 |=> sw_rdata == 32'h0)
		else $error("unmapped read not zero");
	AST_DROP_SRC: assert property (mmr_drop |-> $past(ex_valid))
		else $error("drop without execute word");
	// Main scenarios
	cover property (mmr_drop);
	cover property (in_valid && hold_r);
	cover property (sw_rd && sw_addr == 8'h60);
endmodule // dph_pipe_ctrl_props
`default_nettype wire

// ===== bench/test_dph_pipe_ctrl.sv
/* Self-checking bench of the pipeline control block: word sequences and
   software port accesses. Assumes the checker file is compiled first. */
`timescale 1ns/1ns
`default_nettype none
module test_dph_pipe_ctrl;
	// Design inputs
	logic        ref_clk, rst, in_valid, in_ar_upd, in_ar_use_idx, in_ar_load, in_ar_cmp;
	logic        in_mmr_wr, in_normalize_op, in_cnf_wr, in_cnf_val, sw_wr, sw_rd;
	logic [4:0]  in_mmr_sel;
	logic [15:0] in_ar_delta, in_ar_load_val, in_mmr_data;
	logic [7:0]  sw_addr;
	logic [31:0] sw_wdata;
	// Design outputs
	wire         op_valid, op_ram_map_select_bit, aux_cmp_tc, ex_valid, mmr_drop;
	wire  [15:0] op_addr, op_processor_mode_reg, ex_global_alloc_reg, ex_dyn_shift_count;
	wire  [15:0] ex_dyn_bit_address, ex_block_move_addr_reg, ex_progdata_wait_reg;
	wire  [15:0] ex_io_wait_reg, ex_wait_control_reg;
	wire  [31:0] sw_rdata;
	// Captured stage views and bookkeeping
	logic [33:0]  oq[$];
	logic [111:0] eq[$];
	logic [15:0]  d;
	int           num_errors, n_checks, nd;
	// Words {op, sel, data} and the aux value each reads in decode
	logic [23:0]  prog[21] = '{24'h200067, 0, 24'h620064, 24'h40ffff, 24'h40ffff, 0, 0,
		24'h620040, 24'h40ffff, 0, 24'h40ffff, 0, 24'h680005, 0, 24'hc00000,
		24'hc00000, 0, 24'h800010, 0, 0, 0};
	logic [15:0]  xa[21] = '{16'h0, 16'h67, 16'h67, 16'h67, 16'h66, 16'h65, 16'h65,
		16'h65, 16'h65, 16'h64, 16'h40, 16'h3f, 16'h3f, 16'h3f, 16'h3f, 16'h3f,
		16'h44, 16'h44, 16'h44, 16'h44, 16'h54};
	logic [4:0]   xs[7] = '{5'h0a, 5'h0c, 5'h0d, 5'h13, 5'h14, 5'h15, 5'h16};
	// Circular section words and the aux value each reads in decode
	logic [23:0]  cprog[15] = '{24'h6e0050, 24'h700052, 24'h72000a, 24'h690051, 24'h200050,
		24'h400001, 24'he00000, 24'h400001, 24'h400001, 24'he00000, 0, 24'h630033, 0,
		24'h400001, 0};
	logic [15:0]  ca[15] = '{16'h54, 16'h54, 16'h54, 16'h54, 16'h54, 16'h50, 16'h51,
		16'h51, 16'h52, 16'h50, 16'h50, 16'h50, 16'h50, 16'h50, 16'h51};

	dph_pipe_ctrl uut (.ref_clk, .rst, .in_valid, .in_ar_upd, .in_ar_use_idx,
		.in_ar_cmp, .in_ar_load, .in_aux_pointer(3'h2), .in_ar_delta,
		.in_ar_load_val, .in_mmr_wr, .in_mmr_sel, .in_mmr_data, .in_normalize_op,
		.in_cnf_wr, .in_cnf_val, .op_valid, .op_addr, .op_processor_mode_reg,
		.op_ram_map_select_bit, .aux_cmp_tc, .ex_valid, .ex_global_alloc_reg,
		.ex_dyn_shift_count, .ex_dyn_bit_address, .ex_block_move_addr_reg,
		.ex_progdata_wait_reg, .ex_io_wait_reg, .ex_wait_control_reg, .mmr_drop,
		.sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);

	// Compare and count
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// One word; op 1 load, 2 step, 3 mapped write, 4 normalize, 5 map bit, 6 index, 7 compare
	task automatic w(input logic [23:0] p);
		@(posedge ref_clk);
		in_valid <= 1'b1;
		in_ar_load <= p[23:21] == 3'd1;
		in_ar_upd <= p[23:21] == 3'd2 || p[23:21] == 3'd6;
		in_ar_use_idx <= p[23:21] == 3'd6;
		in_ar_cmp <= p[23:21] == 3'd7;
		in_mmr_wr <= p[23:21] == 3'd3;
		in_normalize_op <= p[23:21] == 3'd4;
		in_cnf_wr <= p[23:21] == 3'd5;
		in_cnf_val <= p[0];
		in_mmr_sel <= p[20:16];
		{in_mmr_data, in_ar_delta, in_ar_load_val} <= {3{p[15:0]}};
	endtask
	// Let the pipeline drain
	task automatic idle(input int n);
		@(posedge ref_clk);
		in_valid <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask
	// Software port cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= v;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		sw_rd <= 1'b1;
		sw_addr <= a;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		#1 chk(n, sw_rdata, e);
	endtask
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Record words leaving operand fetch and execute
	always @(posedge ref_clk) begin
		if (op_valid === 1'b1)
			oq.push_back({aux_cmp_tc, op_ram_map_select_bit, op_processor_mode_reg, op_addr});
		if (ex_valid === 1'b1)
			eq.push_back({ex_wait_control_reg, ex_io_wait_reg, ex_progdata_wait_reg,
				ex_block_move_addr_reg, ex_dyn_bit_address, ex_dyn_shift_count,
				ex_global_alloc_reg});
		if (mmr_drop === 1'b1)
			nd++;
	end
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		{in_valid, in_ar_upd, in_ar_use_idx, in_ar_load, in_mmr_wr, sw_wr, sw_rd} = '0;
		{in_normalize_op, in_cnf_wr, in_cnf_val, in_mmr_sel, sw_addr, sw_wdata} = '0;
		{in_ar_cmp, in_ar_delta, in_ar_load_val, in_mmr_data} = '0;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		// Aux updates against mapped, index and normalize writes
		foreach (prog[i]) w(prog[i]);
		idle(6);
		chk("op count", oq.size(), 21);
		foreach (xa[i]) chk("op_addr", oq[i][15:0], xa[i]);
		chk("drop pulses", nd, 1);
		rd("aux reg 2", 8'h08, 32'h54);
		rd("drop count", 8'h68, 32'h1);
		rd("unmapped", 8'h7c, 32'h0);
		// Operand-fetch registers: one word of latency
		for (int i = 0; i < 7; i++) begin
			d = 16'h0a50 + 16'(i);
			eq.delete();
			w({3'd3, xs[i], d});
			w(0);
			w(0);
			idle(6);
			chk("ex old", eq[1][16*i+:16], 16'h0);
			chk("ex new", eq[2][16*i+:16], d);
		end
		rd("global alloc", 8'h28, 32'h0a50);
		// Processor mode and map bit: two words of latency
		oq.delete();
		w(24'h6b0030);
		w(24'ha00001);
		w(0);
		w(0);
		w(0);
		idle(6);
		for (int j = 0; j < 5; j++) begin
			chk("mode", oq[j][31:16], j > 2 ? 16'h0030 : 16'h0);
			chk("map bit", oq[j][32], j == 4);
		end
		rd("status", 8'h64, 32'h10);
		// Circular wrap, compare, mapped write to another aux reg
		oq.delete();
		foreach (cprog[i]) w(cprog[i]);
		idle(6);
		chk("circ count", oq.size(), 15);
		foreach (ca[i]) chk("circ addr", oq[i][15:0], ca[i]);
		foreach (ca[i]) chk("compare", oq[i][33], i > 5 && i < 9);
		chk("drop pulses", nd, 1);
		rd("aux reg 2 wrap", 8'h08, 32'h51);
		rd("aux reg 3", 8'h0c, 32'h33);
		// Hold turns a word into a bubble
		wr(8'h60, 32'h1);
		oq.delete();
		w(0);
		idle(6);
		chk("bubble", oq.size(), 0);
		rd("hold", 8'h60, 32'h1);
		wr(8'h60, 32'h0);
		print_verdict();
	end
endmodule // test_dph_pipe_ctrl

bind dph_pipe_ctrl dph_pipe_ctrl_props chk_i (.ref_clk, .rst, .in_valid, .op_valid,
	.ex_valid, .mmr_drop, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
`default_nettype wire
